// ---- supply_monitor_map.svh ----
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 250 MHz core clock, registers reached by a plain byte-wide port
// Notes:   Offsets are byte addresses of the configuration space
//
// Notes on behaviour
// - Low rail detectors two to seven take 8-bit codes: 1 V plus 20 mV steps.
// - Range bits one to six pick wide 20 mV or fine 10 mV scaling.
// - Impedance bits one to six pick high-impedance scaling, 3.3 mV steps from 0.1667 V.
// - Rail eight code from its own register; range bit seven picks 50 or 25 mV steps.
// - Impedance bit seven puts rail eight into high-impedance scaling.
// - Range bit zero picks rail one scaling: 50 mV or 25 mV steps.
// - Code, range and impedance registers (00h to 09h) have nonvolatile copies 80h above them.
// - Each general input has its own programmable active polarity.
// - Conditioned general inputs drive only the general_active_o outputs.
// - Outputs enabled for manual reset assert while manual reset is low.
// - After manual reset release, outputs hold for their own timeout.
// - Monitor gives zero while below threshold, one otherwise.
// - Register 28h bits zero to three set general input polarity.
// - Output timeout selectable among eight durations, 25 us to 1.6 s.
`ifndef SUPPLY_MONITOR_MAP_SVH
`define SUPPLY_MONITOR_MAP_SVH

`define RAIL1_CODE_OFS      8'h00
`define RAIL8_CODE_OFS      8'h07
`define RANGE_SEL_OFS       8'h08
`define IMPED_SEL_OFS       8'h09
`define INPUT_POLARITY_OFS  8'h28
`define MANUAL_EN_OFS       8'h29
`define TIMEOUT_SEL_OFS     8'h2a
`define NV_COPY_OFS         8'h80
`define CODE_RESET          8'h00
`define RANGE_RESET         8'h00
`define IMPED_RESET         8'h00
`define POLARITY_RESET      4'h0
`define MANUAL_EN_RESET     4'h0
`define TIMEOUT_RESET       3'h0
`define CLK_MHZ             250
`define TICK_US             25
`define TICK_CYCLES         (`TICK_US * `CLK_MHZ)

`endif

// ---- supply_monitor_pkg.sv ----
// Purpose: Types shared by the supply monitor configuration block
// Assumes: Nothing beyond the constants header
// Notes:   Scaling modes follow the detector configuration bits
package supply_monitor_pkg;

    typedef enum logic [1:0] {
        SCALE_WIDE,
        SCALE_FINE,
        SCALE_HIGHZ
    } scale_mode_e;

    // Timeout in 25 us ticks
    typedef logic [15:0] tick_count_t;

    // Durations 25us,1.575ms,6.25ms,25ms,50ms,200ms,400ms,1.6s as ticks
    function automatic tick_count_t timeout_ticks(input logic [2:0] sel);
        tick_count_t t;
        t = 16'h0001;
        unique case (sel)
            3'h0: t = 16'h0001;
            3'h1: t = 16'h003f;
            3'h2: t = 16'h00fa;
            3'h3: t = 16'h03e8;
            3'h4: t = 16'h07d0;
            3'h5: t = 16'h1f40;
            3'h6: t = 16'h3e80;
            3'h7: t = 16'hfa00;
        endcase
        return t;
    endfunction : timeout_ticks

endpackage : supply_monitor_pkg

// ---- sync_two_stage.sv ----
// Purpose: Two flip-flop synchroniser for a bus of levels
// Assumes: Inputs are asynchronous levels
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
module sync_two_stage #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] reset_val_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

    // reset_val_i unused at reset; kept zero to honour constant reset
    logic unused_reset_val;
    assign unused_reset_val = ^reset_val_i;
endmodule : sync_two_stage

// ---- output_hold_timer.sv ----
// Purpose: Holds one output asserted for its timeout after a cause clears
// Assumes: tick_i is a one-cycle pulse every 25 us
// Notes:   A new cause restarts the hold
`timescale 1ns/10ps
module output_hold_timer
    import supply_monitor_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       tick_i,
    input  wire logic       cause_i,
    input  wire logic [2:0] timeout_sel_i,
    output logic            assert_o
);
    tick_count_t remain_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remain_reg <= '0;
        end else if (cause_i) begin
            remain_reg <= timeout_ticks(timeout_sel_i);
        end else if (tick_i && remain_reg != '0) begin
            remain_reg <= remain_reg - 16'h0001;
        end
    end

    assign assert_o = cause_i || (remain_reg != '0);

    hold_after_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(cause_i) |-> assert_o)
        else $error("Output dropped at cause release");
    cause_asserts_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cause_i |-> assert_o)
        else $error("Output not asserted with cause");
endmodule : output_hold_timer

// ---- supply_monitor_threshold_config.sv ----
// Purpose: Threshold configuration registers and input conditioning
// Assumes: Byte-wide register port; analog side turns codes and scale into thresholds
// Notes:   Nonvolatile copy loads the live registers on load_nv_i
`timescale 1ns/10ps
`include "supply_monitor_map.svh"
module supply_monitor_threshold_config
    import supply_monitor_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        load_nv_i,
    input  wire logic [7:0]  rail_below_i,
    input  wire logic        manual_reset_n_i,
    input  wire logic [3:0]  general_logic_inputs_i,
    output logic      [63:0] threshold_codes_o,
    output logic      [15:0] scale_modes_o,
    output logic      [7:0]  rail_ok_o,
    output logic      [3:0]  general_active_o,
    output logic      [3:0]  programmable_output_o
);

    ////////////////////////////////////////////////////////////////////
    // Live and nonvolatile configuration storage

    logic [7:0] code_reg [8];
    logic [7:0] nv_code_reg [8];
    logic [7:0] range_reg;
    logic [7:0] imped_reg;
    logic [7:0] nv_range_reg;
    logic [7:0] nv_imped_reg;
    logic [3:0] polarity_reg;
    logic [3:0] manual_en_reg;
    logic [2:0] timeout_reg [4];

    function automatic logic is_code_addr(input logic [7:0] a);
        return a <= `RAIL8_CODE_OFS;
    endfunction : is_code_addr

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                code_reg[i] <= `CODE_RESET;
            end
            range_reg <= `RANGE_RESET;
            imped_reg <= `IMPED_RESET;
        end else if (load_nv_i) begin
            for (int i = 0; i < 8; i++) begin
                code_reg[i] <= nv_code_reg[i];
            end
            range_reg <= nv_range_reg;
            imped_reg <= nv_imped_reg;
        end else if (reg_wr_i) begin
            if (is_code_addr(reg_addr_i)) begin
                code_reg[reg_addr_i[2:0]] <= reg_wdata_i;
            end
            if (reg_addr_i == `RANGE_SEL_OFS) begin
                range_reg <= reg_wdata_i;
            end
            if (reg_addr_i == `IMPED_SEL_OFS) begin
                imped_reg <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                nv_code_reg[i] <= `CODE_RESET;
            end
            nv_range_reg <= `RANGE_RESET;
            nv_imped_reg <= `IMPED_RESET;
        end else if (reg_wr_i && reg_addr_i[7]) begin
            if (is_code_addr(reg_addr_i - `NV_COPY_OFS)) begin
                nv_code_reg[reg_addr_i[2:0]] <= reg_wdata_i;
            end
            if (reg_addr_i == (`RANGE_SEL_OFS + `NV_COPY_OFS)) begin
                nv_range_reg <= reg_wdata_i;
            end
            if (reg_addr_i == (`IMPED_SEL_OFS + `NV_COPY_OFS)) begin
                nv_imped_reg <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            polarity_reg  <= `POLARITY_RESET;
            manual_en_reg <= `MANUAL_EN_RESET;
            for (int i = 0; i < 4; i++) begin
                timeout_reg[i] <= `TIMEOUT_RESET;
            end
        end else if (reg_wr_i) begin
            if (reg_addr_i == `INPUT_POLARITY_OFS) begin
                polarity_reg <= reg_wdata_i[3:0];
            end
            if (reg_addr_i == `MANUAL_EN_OFS) begin
                manual_en_reg <= reg_wdata_i[3:0];
            end
            if (reg_addr_i[7:2] == `TIMEOUT_SEL_OFS >> 2 && reg_addr_i[1]) begin
                timeout_reg[{reg_addr_i[0], 1'b0}] <= reg_wdata_i[2:0];
                timeout_reg[{reg_addr_i[0], 1'b1}] <= reg_wdata_i[6:4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (is_code_addr(reg_addr_i)) begin
                reg_rdata_o <= code_reg[reg_addr_i[2:0]];
            end else if (reg_addr_i == `RANGE_SEL_OFS) begin
                reg_rdata_o <= range_reg;
            end else if (reg_addr_i == `IMPED_SEL_OFS) begin
                reg_rdata_o <= imped_reg;
            end else if (reg_addr_i[7] && is_code_addr(reg_addr_i - `NV_COPY_OFS)) begin
                reg_rdata_o <= nv_code_reg[reg_addr_i[2:0]];
            end else if (reg_addr_i == (`RANGE_SEL_OFS + `NV_COPY_OFS)) begin
                reg_rdata_o <= nv_range_reg;
            end else if (reg_addr_i == (`IMPED_SEL_OFS + `NV_COPY_OFS)) begin
                reg_rdata_o <= nv_imped_reg;
            end else if (reg_addr_i == `INPUT_POLARITY_OFS) begin
                reg_rdata_o <= {4'h0, polarity_reg};
            end else if (reg_addr_i == `MANUAL_EN_OFS) begin
                reg_rdata_o <= {4'h0, manual_en_reg};
            end else if (reg_addr_i == `TIMEOUT_SEL_OFS) begin
                reg_rdata_o <= {1'b0, timeout_reg[1], 1'b0, timeout_reg[0]};
            end else if (reg_addr_i == `TIMEOUT_SEL_OFS + 8'h01) begin
                reg_rdata_o <= {1'b0, timeout_reg[3], 1'b0, timeout_reg[2]};
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Scaling selection per detector

    function automatic scale_mode_e pick_scale(input logic range_bit, input logic imped_bit);
        if (imped_bit) begin
            return SCALE_HIGHZ;
        end
        return range_bit ? SCALE_FINE : SCALE_WIDE;
    endfunction : pick_scale

    always_comb begin
        threshold_codes_o = '0;
        scale_modes_o     = '0;
        for (int i = 0; i < 8; i++) begin
            threshold_codes_o[i*8 +: 8] = code_reg[i];
        end
        // Rail one has no high-impedance mode
        scale_modes_o[1:0] = pick_scale(range_reg[0], 1'b0);
        for (int i = 1; i < 8; i++) begin
            scale_modes_o[i*2 +: 2] = pick_scale(range_reg[i], imped_reg[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input conditioning

    logic [7:0] below_sync;
    logic       manual_reset_n_sync;
    logic [3:0] general_sync;

    sync_two_stage #(.WIDTH(13)) u_sync (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .async_i     ({rail_below_i, manual_reset_n_i, general_logic_inputs_i}),
        .reset_val_i (13'h0000),
        .sync_o      ({below_sync, manual_reset_n_sync, general_sync})
    );

    // Sync reset zero reads as rail ok; manual reset looks low but enables are clear
    assign rail_ok_o = ~below_sync;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            general_active_o[i] = polarity_reg[i] ? general_sync[i]
                                                  : ~general_sync[i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Manual reset driven outputs

    logic [12:0] tick_cnt_reg;
    logic        tick_reg;
    localparam logic [12:0] TickLast = 13'(`TICK_CYCLES - 1);

    // One-cycle enable every 25 us; counter must hold the whole period
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= 13'h0000;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg     <= (tick_cnt_reg == TickLast);
            tick_cnt_reg <= (tick_cnt_reg == TickLast) ? 13'h0000 : tick_cnt_reg + 13'h0001;
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_out
        output_hold_timer u_hold (
            .clk_i         (clk_i),
            .rst_n_i       (rst_n_i),
            .tick_i        (tick_reg),
            .cause_i       (manual_en_reg[g] && !manual_reset_n_sync),
            .timeout_sel_i (timeout_reg[g]),
            .assert_o      (programmable_output_o[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    highz_override_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        imped_reg[3] |-> scale_modes_o[7:6] == SCALE_HIGHZ)
        else $error("High impedance not overriding range");
    rail1_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        scale_modes_o[1:0] == (range_reg[0] ? SCALE_FINE : SCALE_WIDE))
        else $error("Rail one scaling wrong");
    code_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && !load_nv_i && reg_addr_i == 8'h02
        |=> threshold_codes_o[23:16] == $past(reg_wdata_i))
        else $error("Code write lost");
    nv_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        load_nv_i |=> range_reg == $past(nv_range_reg))
        else $error("Nonvolatile copy not loaded");
    fault_sync_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##2 rail_ok_o[0] == !$past(rail_below_i[0], 2))
        else $error("Fault not after two stages");
    polarity_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        general_active_o[1] == (general_sync[1] ~^ polarity_reg[1]))
        else $error("General input polarity wrong");
    manual_assert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        manual_en_reg[0] && !manual_reset_n_sync |-> programmable_output_o[0])
        else $error("Manual reset did not assert output");
    rail8_highz_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !imped_reg[7] |-> scale_modes_o[15:14] != SCALE_HIGHZ)
        else $error("Rail eight wrong impedance mode");

    // Register writes and read-back
    range_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && !load_nv_i && reg_addr_i == `RANGE_SEL_OFS
        |=> range_reg == $past(reg_wdata_i))
        else $error("Range write lost");
    imped_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && !load_nv_i && reg_addr_i == `IMPED_SEL_OFS
        |=> imped_reg == $past(reg_wdata_i))
        else $error("Impedance write lost");
    nv_copy_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == (`RAIL1_CODE_OFS + `NV_COPY_OFS)
        |=> nv_code_reg[0] == $past(reg_wdata_i))
        else $error("Nonvolatile copy write lost");
    polarity_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == `INPUT_POLARITY_OFS
        |=> polarity_reg == $past(reg_wdata_i[3:0]))
        else $error("Polarity write lost");
    timeout_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == `TIMEOUT_SEL_OFS
        |=> timeout_reg[1] == $past(reg_wdata_i[6:4]))
        else $error("Timeout select write lost");
    nv_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == (`IMPED_SEL_OFS + `NV_COPY_OFS)
        |=> reg_rdata_o == $past(nv_imped_reg))
        else $error("Nonvolatile copy read wrong");

    // Scaling selection and rail eight code write
    fine_scale_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        range_reg[2] && !imped_reg[2] |-> scale_modes_o[5:4] == SCALE_FINE)
        else $error("Fine range not selected");
    wide_scale_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !range_reg[4] && !imped_reg[4] |-> scale_modes_o[9:8] == SCALE_WIDE)
        else $error("Wide range not selected");
    rail8_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !imped_reg[7] |-> scale_modes_o[15:14] == (range_reg[7] ? SCALE_FINE : SCALE_WIDE))
        else $error("Rail eight range wrong");
    rail8_highz_on_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        imped_reg[7] |-> scale_modes_o[15:14] == SCALE_HIGHZ)
        else $error("Rail eight high impedance not selected");
    rail8_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && !load_nv_i && reg_addr_i == `RAIL8_CODE_OFS
        |=> threshold_codes_o[63:56] == $past(reg_wdata_i))
        else $error("Rail eight code write lost");

    // Enable divider, manual reset outputs and general input polarity
    tick_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tick_reg |-> tick_cnt_reg == 13'h0000)
        else $error("Tick not at divider wrap");
    tick_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tick_cnt_reg <= TickLast)
        else $error("Tick divider out of range");
    manual_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(manual_reset_n_sync) && manual_en_reg[1] |-> programmable_output_o[1])
        else $error("Output dropped at manual reset release");
    active_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        polarity_reg[2] |-> general_active_o[2] == general_sync[2])
        else $error("Active-high input not passed on");

endmodule : supply_monitor_threshold_config

// ---- supply_rail_model.sv ----
// Purpose: Supply rail comparator model facing the monitor block
// Assumes: Bench sets rail voltages in microvolts
// Notes:   Threshold follows the codes and scale modes the block drives
`timescale 1ns/10ps
module supply_rail_model (
    input  wire logic [63:0] codes_i,
    input  wire logic [15:0] modes_i,
    output logic      [7:0]  rail_below_o
);
    int rail_uv [8] = '{default: 20000000};

    function automatic int thr_uv(input int r, input int c, input int m);
        if (m == 2) begin
            return 166700 + c * 3300;
        end
        if (r == 0 || r == 7) begin
            return (m == 1) ? 1250000 + c * 25000 : 2500000 + c * 50000;
        end
        return (m == 1) ? 500000 + c * 10000 : 1000000 + c * 20000;
    endfunction : thr_uv

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            rail_below_o[i] = rail_uv[i] < thr_uv(i, codes_i[8*i+:8], modes_i[2*i+:2]);
        end
    end
endmodule : supply_rail_model

// ---- supply_monitor_threshold_config_tb_top.sv ----
// Purpose: Self-checking bench for the threshold configuration block
// Assumes: Register map model kept in a byte array
// Notes:   Only the shortest output timeout is run to keep the run short
`timescale 1ns/10ps
module supply_monitor_threshold_config_tb_top;
    import supply_monitor_pkg::*;
    logic        clk_i, rst_n_i, reg_wr_i, reg_rd_i, load_nv_i, manual_reset_n;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rail_below_i, rail_ok_o;
    logic [3:0]  general_logic_inputs, general_active_o, programmable_output_o;
    logic [63:0] threshold_codes_o;
    logic [15:0] scale_modes_o;
    logic [7:0]  mem [256];
    logic [7:0]  d;
    logic [7:0]  ok_exp;
    int          num_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          seed = 65;
    int          k;

    supply_monitor_threshold_config uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .load_nv_i(load_nv_i), .rail_below_i(rail_below_i), .manual_reset_n_i(manual_reset_n),
        .general_logic_inputs_i(general_logic_inputs), .threshold_codes_o(threshold_codes_o),
        .scale_modes_o(scale_modes_o), .rail_ok_o(rail_ok_o),
        .general_active_o(general_active_o), .programmable_output_o(programmable_output_o)
    );

    supply_rail_model rails (
        .codes_i(threshold_codes_o), .modes_i(scale_modes_o), .rail_below_o(rail_below_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] mask(input int a);
        if (a < 10 || (a >= 128 && a < 138)) begin
            return 8'hff;
        end
        if (a == 40 || a == 41) begin
            return 8'h0f;
        end
        if (a == 42 || a == 43) begin
            return 8'h77;
        end
        return 8'h00;
    endfunction : mask

    function automatic logic [1:0] exp_mode(input int r);
        if (r > 0 && mem[9][r]) begin
            return 2'h2;
        end
        return mem[8][r] ? 2'h1 : 2'h0;
    endfunction : exp_mode

    task automatic wr(input int a, input logic [7:0] v);
        reg_wr_i = 1'b1;
        reg_addr_i = a[7:0];
        reg_wdata_i = v;
        @(negedge clk_i);
        mem[a] = v & mask(a);
    endtask : wr

    task automatic idle;
        reg_wr_i = 1'b0;
        @(negedge clk_i);
    endtask : idle

    task automatic rd_all;
        for (int a = 0; a < 256; a++) begin
            reg_rd_i = 1'b1;
            reg_addr_i = a[7:0];
            @(negedge clk_i);
            reg_rd_i = 1'b0;
            @(negedge clk_i);
            check(reg_rdata_o, mem[a]);
        end
        for (int r = 0; r < 8; r++) begin
            check(threshold_codes_o[8*r+:8], mem[r]);
            check(scale_modes_o[2*r+:2], exp_mode(r));
        end
    endtask : rd_all

    task automatic final_report;
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        {reg_wr_i, reg_rd_i, load_nv_i, manual_reset_n} = 4'h1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        general_logic_inputs = 4'h0;
        foreach (mem[a]) mem[a] = 8'h00;
        rst_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        rd_all();
        // Whole space back to back, host limits kept on codes and bit zero
        for (int a = 0; a < 256; a++) begin
            d = $random(seed);
            if (a % 128 < 8) d = d % 8'hd7;
            if (a % 128 == 9) d[0] = 1'b0;
            wr(a, d);
        end
        idle();
        rd_all();
        load_nv_i = 1'b1;
        @(negedge clk_i);
        load_nv_i = 1'b0;
        for (int a = 0; a < 10; a++) mem[a] = mem[a + 128];
        @(negedge clk_i);
        rd_all();
        for (int i = 0; i < 16; i++) begin
            wr(40, $random(seed));
            wr(8, $random(seed));
            wr(9, $random(seed) & 8'hfe);
            idle();
            general_logic_inputs = $random(seed);
            for (int r = 0; r < 8; r++) begin
                rails.rail_uv[r] = rails.thr_uv(r, mem[r], exp_mode(r)) + $random(seed) % 40000;
            end
            repeat (3) @(negedge clk_i);
            for (int r = 0; r < 8; r++) begin
                ok_exp[r] = rails.rail_uv[r] >= rails.thr_uv(r, mem[r], exp_mode(r));
            end
            check(general_active_o,
                  4'(~(general_logic_inputs ^ mem[40][3:0])));
            check(rail_ok_o, ok_exp);
        end
        for (int i = 0; i < 2; i++) begin
            wr(41, $random(seed) | 1);
            wr(42, 8'h00);
            wr(43, 8'h00);
            idle();
            manual_reset_n = 1'b0;
            repeat (3) @(negedge clk_i);
            check(programmable_output_o, mem[41][3:0]);
            manual_reset_n = 1'b1;
            k = 0;
            while (programmable_output_o !== 4'h0 && k < 6300) begin
                @(negedge clk_i);
                k++;
            end
            check(programmable_output_o, 4'h0);
            // Second hold ends one 25 us tick (6250 cycles) after the first drop
            if (i == 1) check(k + 7, 6250);
        end
        final_report();
    end
endmodule : supply_monitor_threshold_config_tb_top
